/* arcd_decoder.v */
`timescale 1ns/1ns
`include "arcd_defs.vh"

module arcd_decoder #(
  parameter FOUR_CH = 1,
  parameter DATA_W  = `ARCD_DATA_W
) (
  input  wire              clk_sys,
  input  wire              reset_n,
  input  wire              sclk_pin,
  input  wire              sdi_pin,
  input  wire              cs_n_pin,
  input  wire [DATA_W-1:0] reg_rdata,
  output reg               sdo_o,
  output reg               sdo_oe_n,
  output reg               reg_rd_r,
  output reg               reg_wr_r,
  output reg  [1:0]        reg_sel_r,
  output reg  [1:0]        register_index_r,
  output reg  [DATA_W-1:0] reg_wdata_r,
  output reg               cmd_bad_r
);
  // ========================================================================
  // Timing limits of the serial port
  // Serial clock is oversampled, never used as a clock
  // Each half period of it must span several system clocks
  // Select is seen two cycles late, so hold it past the last edge
  // A frame cut by select drops its partial byte or word
  // Read data must be ready in the same cycle as the read strobe

  // ========================================================================
  // Local states
  localparam ST_CMD  = 2'h0;
  localparam ST_WDAT = 2'h1;
  localparam ST_RDAT = 2'h2;

  // ========================================================================
  // Command decoding
  // Upper index pair exists only on four-channel parts
  function idx_in_range;
    input [7:0] b;
    begin
      idx_in_range = (FOUR_CH != 0) || !b[`ARCD_IDX_HI];
    end
  endfunction

  // Command decode: returns select code, NONE if the byte is not ours
  function [1:0] dec_sel;
    input [7:0] b;
    begin
      dec_sel = `ARCD_SEL_NONE;
      if (b[7:6] == `ARCD_TOP2_IND) begin
        case (b[2:0])
          `ARCD_OP_OFFSET: dec_sel = `ARCD_SEL_OFFSET;
          `ARCD_OP_GAIN:   dec_sel = `ARCD_SEL_GAIN;
          `ARCD_OP_SETUP:  dec_sel = `ARCD_SEL_SETUP;
          default:         dec_sel = `ARCD_SEL_NONE;
        endcase
        // Upper index only on four-channel parts, setup excepted
        if (!idx_in_range(b) &&
            (dec_sel == `ARCD_SEL_OFFSET || dec_sel == `ARCD_SEL_GAIN))
          dec_sel = `ARCD_SEL_NONE;
      end
    end
  endfunction

  // Configuration has its own code; index bits must be zero
  function is_cfg;
    input [7:0] b;
    begin
      is_cfg = (b[7:4] == `ARCD_TOP4_CFG) && (b[2:0] == `ARCD_OP_CONFIG);
    end
  endfunction

  // Last bit of a data word, shared by the write and read paths
  function at_word_end;
    input [`ARCD_CNT_W-1:0] c;
    begin
      at_word_end = (c == DATA_W[`ARCD_CNT_W-1:0] - 6'h01);
    end
  endfunction

  // ========================================================================
  // Pin synchronisers, two stages each before any use
  reg [1:0] sclk_s_r, sdi_s_r, csn_s_r;
  reg       sclk_d_r;
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      sclk_s_r <= 2'h0;
      sdi_s_r  <= 2'h0;
      // Select starts high so no false frame follows reset
      csn_s_r  <= 2'h3;
      sclk_d_r <= 1'b0;
    end else begin
      sclk_s_r <= {sclk_s_r[0], sclk_pin};
      sdi_s_r  <= {sdi_s_r[0], sdi_pin};
      csn_s_r  <= {csn_s_r[0], cs_n_pin};
      sclk_d_r <= sclk_s_r[1];
    end
  end

  // Edge strobes from the synchronised serial clock
  wire sclk_rise = sclk_s_r[1] & ~sclk_d_r;
  wire sclk_fall = ~sclk_s_r[1] & sclk_d_r;
  wire sel_n     = csn_s_r[1];

  // ========================================================================
  // Shift engine; SCLK is only sampled at clk_sys, so it must run slower
  reg [1:0]            st_r;
  reg [`ARCD_CNT_W-1:0] cnt_r;
  reg [7:0]            cmd_r;
  reg [DATA_W-1:0]     sh_r;
  wire [7:0]           cmd_nxt = {cmd_r[6:0], sdi_s_r[1]};
  wire [1:0]           sel_nxt = dec_sel(cmd_nxt);
  wire                 cfg_nxt = is_cfg(cmd_nxt);
  // Set by a read command; the fall that ends the command byte must not shift
  reg                  skip_r;

  // One process walks the command byte, the write word and the read word
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      // Idle values: port released, strobes low
      st_r             <= ST_CMD;
      skip_r           <= 1'b0;
      cnt_r            <= {`ARCD_CNT_W{1'b0}};
      cmd_r            <= 8'h00;
      sh_r             <= {DATA_W{1'b0}};
      sdo_o            <= 1'b0;
      sdo_oe_n         <= 1'b1;
      reg_rd_r         <= 1'b0;
      reg_wr_r         <= 1'b0;
      reg_sel_r        <= `ARCD_SEL_NONE;
      register_index_r <= 2'h0;
      reg_wdata_r      <= {DATA_W{1'b0}};
      cmd_bad_r        <= 1'b0;
    end else begin
      reg_rd_r <= 1'b0;
      reg_wr_r <= 1'b0;
      // Deselect aborts any partial byte or word
      if (sel_n) begin
        st_r     <= ST_CMD;
        cnt_r    <= {`ARCD_CNT_W{1'b0}};
        sdo_oe_n <= 1'b1;
        skip_r   <= 1'b0;
      end else begin
        case (st_r)
          // Command byte: eight rises, MSB first
          ST_CMD: if (sclk_rise) begin
            cmd_r <= cmd_nxt;
            // Eighth bit: decode the byte with this bit included
            if (cnt_r == 6'h07) begin
              cnt_r     <= {`ARCD_CNT_W{1'b0}};
              cmd_bad_r <= 1'b0;
              register_index_r <= cmd_nxt[`ARCD_IDX_HI:`ARCD_IDX_LO];
              if (cfg_nxt || sel_nxt != `ARCD_SEL_NONE) begin
                // Config shares the NONE code and is told apart by it
                reg_sel_r <= cfg_nxt ? `ARCD_SEL_NONE : sel_nxt;
                if (cmd_nxt[`ARCD_BIT_DIR] == `ARCD_DIR_READ) begin
                  reg_rd_r <= 1'b1;
                  skip_r   <= 1'b1;
                  st_r     <= ST_RDAT;
                end else begin
                  st_r <= ST_WDAT;
                end
              end else begin
                // Refused bytes leave the select code as it was
                cmd_bad_r <= 1'b1;                     // Not a byte for this block
              end
            end else begin
              cnt_r <= cnt_r + 6'h01;
            end
          end

          // Write word: one bit per rise, strobe on the last
          ST_WDAT: if (sclk_rise) begin
            sh_r <= {sh_r[DATA_W-2:0], sdi_s_r[1]};
            // Last bit joins the word now, not a cycle later
            if (at_word_end(cnt_r)) begin
              reg_wdata_r <= {sh_r[DATA_W-2:0], sdi_s_r[1]};
              reg_wr_r    <= 1'b1;
              cnt_r       <= {`ARCD_CNT_W{1'b0}};
              st_r        <= ST_CMD;
            end else begin
              cnt_r <= cnt_r + 6'h01;
            end
          end

          // Read word: MSB stands before the first data rise, one shift per fall
          ST_RDAT: begin
            // Read data is latched while the read strobe is high
            if (reg_rd_r) begin
              sh_r     <= reg_rdata;
              sdo_o    <= reg_rdata[DATA_W-1];
              sdo_oe_n <= 1'b0;
            end else if (sclk_fall && skip_r) begin
              // Host still has to sample the MSB on its next rise
              skip_r <= 1'b0;
            end else if (sclk_fall) begin
              sh_r  <= {sh_r[DATA_W-2:0], 1'b0};
              sdo_o <= sh_r[DATA_W-2];
              if (at_word_end(cnt_r)) begin
                cnt_r    <= {`ARCD_CNT_W{1'b0}};
                sdo_oe_n <= 1'b1;
                st_r     <= ST_CMD;
              end else begin
                cnt_r <= cnt_r + 6'h01;
              end
            end
          end
          default: st_r <= ST_CMD;
        endcase
      end
    end
  end
endmodule // arcd_decoder

/* arcd_defs.vh */
`ifndef ARCD_DEFS_VH
`define ARCD_DEFS_VH
// ==========================================================================
// Command byte layout
`define ARCD_CMD_W        8
`define ARCD_DATA_W       32
`define ARCD_CNT_W        6
`define ARCD_BIT_DIR      3
`define ARCD_IDX_HI       5
`define ARCD_IDX_LO       4
// Opcode field D2..D0
`define ARCD_OP_OFFSET    3'h1
`define ARCD_OP_GAIN      3'h2
`define ARCD_OP_CONFIG    3'h3
`define ARCD_OP_SETUP     3'h5
// Upper bits D7..D6 for individual access, D7..D4 for configuration
`define ARCD_TOP2_IND     2'h0
`define ARCD_TOP4_CFG     4'h0
// Register select codes
`define ARCD_SEL_NONE     2'h0
`define ARCD_SEL_OFFSET   2'h1
`define ARCD_SEL_GAIN     2'h2
`define ARCD_SEL_SETUP    2'h3
// Direction values
`define ARCD_DIR_WRITE    1'b0
`define ARCD_DIR_READ     1'b1
`endif

/* arcd_decoder_properties.sv */
`timescale 1ns/1ns
`include "arcd_defs.vh"
// ==========================================
// Port-level checks on the command decoder
module arcd_decoder_properties #(parameter DATA_W = 32) (
  input wire clk_sys, input wire reset_n, input wire sclk_pin, input wire sdi_pin,
  input wire cs_n_pin, input wire [DATA_W-1:0] reg_rdata, input wire sdo_o,
  input wire sdo_oe_n, input wire reg_rd_r, input wire reg_wr_r, input wire [1:0] reg_sel_r,
  input wire [1:0] register_index_r, input wire [DATA_W-1:0] reg_wdata_r,
  input wire cmd_bad_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Read strobe is single cycle; strobes never overlap
  property p_pulse; reg_rd_r |=> !reg_rd_r; endproperty
  a_pulse: assert property (p_pulse) else $error("read strobe too long");
  property p_excl; !(reg_rd_r && reg_wr_r); endproperty
  a_excl: assert property (p_excl) else $error("read and write together");
  property p_rdoe; reg_rd_r |=> !sdo_oe_n; endproperty
  a_rdoe: assert property (p_rdoe) else $error("read word not driven");
  property p_oew; reg_wr_r |-> sdo_oe_n; endproperty
  a_oew: assert property (p_oew) else $error("output driven on write");
  property p_bad; cmd_bad_r |-> !reg_rd_r && !reg_wr_r; endproperty
  a_bad: assert property (p_bad) else $error("refused byte gave a strobe");
  // Deselected port must stay quiet once the sync delay has passed
  property p_idle; cs_n_pin [*5] |-> !reg_wr_r && $stable(reg_sel_r); endproperty
  a_idle: assert property (p_idle) else $error("activity while deselected");
  property p_wrcs; reg_wr_r |-> !$past(cs_n_pin, 3); endproperty
  a_wrcs: assert property (p_wrcs) else $error("write outside a frame");
  property p_cfg; (reg_wr_r || reg_rd_r) && reg_sel_r == `ARCD_SEL_NONE
    |-> register_index_r == 2'h0; endproperty
  a_cfg: assert property (p_cfg) else $error("config with nonzero index");
  c_wr: cover property (reg_wr_r);
  c_rd: cover property (reg_rd_r);
  c_bad: cover property ($rose(cmd_bad_r));
endmodule // arcd_decoder_properties
bind arcd_decoder arcd_decoder_properties #(.DATA_W(DATA_W)) i_arcd_decoder_properties (.*);

/* arcd_host.sv */
`timescale 1ns/1ns
// ==========================================
// Host driving command bytes and data words
module arcd_host (
  input wire clk_sys, input wire sdo, output reg sclk, output reg sdi, output reg cs_n
);
  integer b;
  initial begin sclk = 0; sdi = 0; cs_n = 1; end
  // SCLK runs only inside the frame; slow half periods suit the input sync
  task xfer(input [39:0] v, input integer n, output [31:0] r);
    begin
      r = 0;
      @(negedge clk_sys) cs_n = 0;
      for (b = 39; b > 39 - n; b = b - 1) begin
        sdi = v[b];
        repeat (8) @(negedge clk_sys);
        r = {r[30:0], sdo};
        sclk = 1;
        repeat (8) @(negedge clk_sys);
        sclk = 0;
      end
      repeat (8) @(negedge clk_sys);
      cs_n = 1;
      sdi = ~sdi;
      // Select stays high long enough to pass the two-stage sync
      repeat (4) @(negedge clk_sys);
    end
  endtask
endmodule // arcd_host

/* adc_register_access_command_decoder_bench.sv */
`timescale 1ns/1ns
`include "arcd_defs.vh"
// ==========================================
// Bench for the command decoder
module adc_register_access_command_decoder_bench;
  reg clk_sys = 0, reset_n = 0, bad_e;
  reg [31:0] reg_rdata = 32'h0, got;
  wire sclk, sdi, cs_n, sdo_o, sdo_oe_n, rd, wr, bad;
  wire [1:0] sel, idx;
  wire [31:0] wdata;
  integer fails = 0, n_tests = 0, cyc = 0, n_wr = 0, n_rd = 0;
  // Released SDO shows the inverse of its last bit, so a stale bit cannot pass
  wire sdo_w = sdo_oe_n ? ~sdo_o : sdo_o;
  initial forever #25 clk_sys = ~clk_sys;
  arcd_decoder i_arcd_decoder (.clk_sys(clk_sys), .reset_n(reset_n), .sclk_pin(sclk),
    .sdi_pin(sdi), .cs_n_pin(cs_n), .reg_rdata(reg_rdata), .sdo_o(sdo_o),
    .sdo_oe_n(sdo_oe_n), .reg_rd_r(rd), .reg_wr_r(wr), .reg_sel_r(sel),
    .register_index_r(idx), .reg_wdata_r(wdata), .cmd_bad_r(bad));
  arcd_host i_arcd_host (.clk_sys(clk_sys), .sdo(sdo_w), .sclk(sclk), .sdi(sdi), .cs_n(cs_n));
  // Store answers with a word that names the selected register
  always @(negedge clk_sys) reg_rdata <= {28'hC3A55A3, sel, idx};
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (wr) n_wr = n_wr + 1;
    if (rd) n_rd = n_rd + 1;
    if (cyc == 40000) begin fails = fails + 1; conclude; end
  end
  task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    begin
      n_tests = n_tests + 1;
      if (e !== g) begin fails = fails + 1; $display("unexpected %0s %h %h", nm, e, g); end
    end
  endtask
  function [7:0] cmd(input [1:0] k, input [1:0] j, input d);
    cmd = {2'h0, j, d, k == 0 ? `ARCD_OP_CONFIG : k == 1 ? `ARCD_OP_OFFSET :
      k == 2 ? `ARCD_OP_GAIN : `ARCD_OP_SETUP};
  endfunction
  // Every kind and index written; config with an index is refused
  task t_write;
    integer i, w0;
    begin
      for (i = 0; i < 16; i = i + 1) begin
        w0 = n_wr;
        bad_e = i[3:2] == 0 && i[1:0] != 0;
        i_arcd_host.xfer({cmd(i[3:2], i[1:0], `ARCD_DIR_WRITE), 32'h96E10000 + i},
          bad_e ? 8 : 40, got);
        chk("bad", bad_e, bad);
        chk("nwr", bad_e ? w0 : w0 + 1, n_wr);
        chk("nrd", 0, n_rd);
        if (!bad_e) chk("sel", i[3:2], sel);
        if (!bad_e) chk("idx", i[1:0], idx);
        if (!bad_e) chk("wdata", 32'h96E10000 + i, wdata);
      end
    end
  endtask
  // Read back every register kind and index
  task t_read;
    integer i, w0, r0;
    begin
      for (i = 0; i < 16; i = i + 1) if (i[3:2] != 0 || i[1:0] == 0) begin
        w0 = n_wr;
        r0 = n_rd;
        i_arcd_host.xfer({cmd(i[3:2], i[1:0], `ARCD_DIR_READ), 32'h0}, 40, got);
        chk("rdata", {28'hC3A55A3, i[3:0]}, got);
        chk("nwr", w0, n_wr);
        chk("nrd", r0 + 1, n_rd);
        chk("oen", 1, sdo_oe_n);
      end
    end
  endtask
  // Foreign bytes refused; a word cut short by deselect is dropped
  task t_refuse;
    integer i, w0, r0;
    begin
      w0 = n_wr;
      r0 = n_rd;
      for (i = 0; i < 3; i = i + 1) begin
        i_arcd_host.xfer({i == 0 ? 8'hFF : i == 1 ? 8'h41 : 8'h04, 32'h0}, 8, got);
        chk("bad", 1, bad);
      end
      i_arcd_host.xfer({cmd(2'h1, 2'h0, `ARCD_DIR_WRITE), 32'hFFFF0000}, 20, got);
      chk("nwr", w0, n_wr);
      chk("nrd", r0, n_rd);
      chk("wdata", 32'h96E1000F, wdata);
    end
  endtask
  task conclude;
    begin
      if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    repeat (12) @(negedge clk_sys);
    reset_n = 1;
    repeat (4) @(negedge clk_sys);
    t_write;
    t_read;
    t_refuse;
    conclude;
  end
endmodule // adc_register_access_command_decoder_bench
